// *** core/tone_host_port.sv ***
// host nibble port and tone-pair steering of the dual-tone transceiver
// assumes detector inputs (pair_valid, pair_code, cp_level, tx_burst_done)
// are already on clk; bus strobes and the steering pin are asynchronous
//
// Contract
// - data lines float unless a selected read
// - select is active low, gates all strobes
// - register selector steers each access
// - interrupt mode pulls notify low on burst
// - call-progress mode outputs rectangular filtered tone
// - early detection rises on valid pair
// - early detection drops on any loss
// - steering rise registers pair, starts settle delay
// - steering fall re-arms for next pair
// - guard drive from early detection and steering
// - timing from colour-burst referenced oscillator
// - guard stays high while early detection holds
// - delayed steering flag after settle, pulls notify in interrupt mode
// - code latch on delayed steering, read back
`timescale 1ns/1ps
`default_nettype none
module tone_host_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic register_selector,
    input wire logic [3:0] host_bus_in,
    output logic [3:0] host_bus_out,
    output logic host_bus_oe,
    input wire logic pair_valid,
    input wire logic [3:0] pair_code,
    input wire logic cp_level,
    input wire logic tx_burst_done,
    output logic pair_detected,
    input wire logic steer_guard_pin,
    output logic steer_guard_out,
    output logic steer_guard_oe,
    output logic notify_or_tone_out,
    output logic notify_or_tone_oe,
    output logic xtal_out,
    output logic [3:0] tx_code,
    output logic tx_load,
    output logic [3:0] control
);
    localparam int NSYNC = 9;

    // synchronised pins
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s;
    wire sel_s = pins_s[8];
    wire rd_s = pins_s[7];
    wire wr_s = pins_s[6];
    wire rs_s = pins_s[5];
    wire st_s = pins_s[4];
    wire [3:0] data_s = pins_s[3:0];

    assign pins_raw = {select_n, read_n, write_n, register_selector,
                       steer_guard_pin, host_bus_in};

    // strobes and data pass four flops before any decode
    pin_sync #(
        .WIDTH(NSYNC),
        .INIT(9'h1c0)
    ) pin_sync_inst (
        .clk(clk),
        .reset(reset),
        .pin(pins_raw),
        .level(pins_s)
    );

    // previous strobe levels for edge detection
    logic rd_prev_q;
    logic wr_prev_q;
    logic st_prev_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
            st_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_s;
            wr_prev_q <= wr_s;
            st_prev_q <= st_s;
        end
    end

    // bus decode; the host is trusted to gate select with its latch enable,
    // so an address phase never shows as a select here
    wire selected = ~sel_s;
    wire rd_active = selected & ~rd_s;
    wire rd_end = selected & rd_s & ~rd_prev_q;
    wire wr_end = selected & wr_s & ~wr_prev_q;
    wire wr_data = wr_end & (rs_s == tone_port_pkg::SEL_DATA);
    wire wr_ctrl = wr_end & (rs_s == tone_port_pkg::SEL_CTRL);
    wire rd_stat_end = rd_end & (rs_s == tone_port_pkg::SEL_CTRL);
    wire st_rise = st_s & ~st_prev_q;
    wire st_fall = ~st_s & st_prev_q;

    // colour-burst reference: phase accumulator at the crystal rate
    logic [tone_port_pkg::PHASE_W-1:0] phase_q;
    logic xtal_q;
    wire [tone_port_pkg::PHASE_W-1:0] phase_d = phase_q + tone_port_pkg::PHASE_INC;
    wire osc_tick = phase_d[tone_port_pkg::PHASE_W-1] & ~phase_q[tone_port_pkg::PHASE_W-1];

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= '0;
            xtal_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            xtal_q <= phase_q[tone_port_pkg::PHASE_W-1];
        end
    end

    // early detection follows the detector with one flop of delay
    logic pair_det_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            pair_det_q <= 1'b0;
        end else begin
            pair_det_q <= pair_valid;
        end
    end

    // steering sequence
    tone_port_pkg::steer_e state_q;
    tone_port_pkg::steer_e state_d;
    logic [tone_port_pkg::SETTLE_W-1:0] settle_q;
    logic [tone_port_pkg::SETTLE_W-1:0] settle_d;
    logic [3:0] pend_code_q;
    logic [3:0] rx_code_q;
    logic dsteer_q;
    logic rx_ready_q;

    wire settle_done = (settle_q == tone_port_pkg::SETTLE_W'(tone_port_pkg::SETTLE_OSC_PERIODS));
    wire do_register = (state_q == tone_port_pkg::ST_ARMED) & st_rise;
    wire dsteer_rise = (state_q == tone_port_pkg::ST_SETTLE) & settle_done & st_s;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        unique case (state_q)
            tone_port_pkg::ST_ARMED: begin
                settle_d = '0;
                if (st_rise) begin
                    state_d = tone_port_pkg::ST_SETTLE;
                end
            end
            tone_port_pkg::ST_SETTLE: begin
                if (~st_s) begin
                    state_d = tone_port_pkg::ST_ARMED;
                end else if (settle_done) begin
                    state_d = tone_port_pkg::ST_HELD;
                end else if (osc_tick) begin
                    settle_d = settle_q + 1'b1;
                end
            end
            tone_port_pkg::ST_HELD: begin
                if (st_fall) begin
                    state_d = tone_port_pkg::ST_ARMED;
                end
            end
            default: begin
                state_d = tone_port_pkg::ST_ARMED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= tone_port_pkg::ST_ARMED;
            settle_q <= '0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // pair taken on registration, shown to the host on the delayed-steering edge
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_code_q <= tone_port_pkg::NIBBLE_RESET;
            rx_code_q <= tone_port_pkg::NIBBLE_RESET;
            dsteer_q <= 1'b0;
        end else begin
            if (do_register) begin
                pend_code_q <= pair_code;
            end
            if (dsteer_rise) begin
                rx_code_q <= pend_code_q;
            end
            dsteer_q <= (state_d == tone_port_pkg::ST_HELD);
        end
    end

    // guard: released while the capacitor charges, held high once registered
    // while early detection holds, pulled low otherwise to reset the timing
    wire registered = (state_q != tone_port_pkg::ST_ARMED);
    wire guard_hi = pair_det_q & registered;
    wire guard_lo = ~pair_det_q;
    logic guard_out_q;
    logic guard_oe_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            guard_out_q <= 1'b0;
            guard_oe_q <= 1'b0;
        end else begin
            guard_out_q <= guard_hi;
            guard_oe_q <= guard_hi | guard_lo;
        end
    end

    // host-written registers
    logic [3:0] ctrl_q;
    logic [3:0] tx_code_q;
    logic tx_load_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= tone_port_pkg::CTRL_RESET;
            tx_code_q <= tone_port_pkg::NIBBLE_RESET;
            tx_load_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= data_s;
            end
            if (wr_data) begin
                tx_code_q <= data_s;
            end
            tx_load_q <= wr_data;
        end
    end

    wire irq_en = ctrl_q[tone_port_pkg::CTRL_IRQ_EN];
    wire cp_mode = ctrl_q[tone_port_pkg::CTRL_CP_MODE];

    // sticky event flags: an event in the clearing cycle survives the clear
    logic tx_done_q;
    wire rx_event = dsteer_rise;
    wire tx_done_d = tx_burst_done | (tx_done_q & ~rd_stat_end);
    wire rx_ready_d = rx_event | (rx_ready_q & ~(rd_end & (rs_s == tone_port_pkg::SEL_DATA)));

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_done_q <= 1'b0;
            rx_ready_q <= 1'b0;
        end else begin
            tx_done_q <= tx_done_d;
            rx_ready_q <= rx_ready_d;
        end
    end

    // status nibble as the host sees it
    wire irq_pend = tx_done_q | rx_ready_q | dsteer_q;
    wire [3:0] status_nib = {dsteer_q, rx_ready_q, tx_done_q, irq_pend};
    wire [3:0] read_nib = (rs_s == tone_port_pkg::SEL_CTRL) ? status_nib : rx_code_q;

    // bus drive, only during a selected read
    logic [3:0] bus_out_q;
    logic bus_oe_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            bus_out_q <= tone_port_pkg::NIBBLE_RESET;
            bus_oe_q <= 1'b0;
        end else begin
            bus_out_q <= read_nib;
            bus_oe_q <= rd_active;
        end
    end

    // notify pin: open drain, pulled low by driving its enable
    // call-progress mode takes priority because it reuses the same pin
    wire notify_irq = irq_en & (tx_done_q | rx_ready_q | dsteer_q);
    wire notify_cp = ~cp_level;
    wire notify_pull = cp_mode ? notify_cp : notify_irq;
    logic notify_oe_q;
    logic notify_out_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            notify_oe_q <= 1'b0;
            notify_out_q <= 1'b0;
        end else begin
            notify_oe_q <= notify_pull;
            notify_out_q <= 1'b0;
        end
    end

    assign host_bus_out = bus_out_q;
    assign host_bus_oe = bus_oe_q;
    assign pair_detected = pair_det_q;
    assign steer_guard_out = guard_out_q;
    assign steer_guard_oe = guard_oe_q;
    assign notify_or_tone_out = notify_out_q;
    assign notify_or_tone_oe = notify_oe_q;
    assign xtal_out = xtal_q;
    assign tx_code = tx_code_q;
    assign tx_load = tx_load_q;
    assign control = ctrl_q;
endmodule : tone_host_port
`default_nettype wire

// *** inc/tone_port_pkg.sv ***
// constants for the tone transceiver host port and steering logic
// assumes a 100 MHz system clock feeding every register of the block
package tone_port_pkg;

    // system clock and colour-burst reference
    localparam longint CLK_HZ = 100000000;
    localparam longint XTAL_HZ = 3579545;
    localparam int PHASE_W = 32;
    localparam logic [31:0] PHASE_INC = 32'(((XTAL_HZ << PHASE_W) + CLK_HZ / 2) / CLK_HZ);

    // latch settling delay before the delayed-steering flag, in oscillator periods
    localparam int SETTLE_OSC_PERIODS = 4;
    localparam int SETTLE_W = 4;

    // pin synchroniser depth and width of the host nibble bus
    localparam int SYNC_STAGES = 3;
    localparam int BUS_W = 4;

    // register-select levels
    localparam logic SEL_DATA = 1'b0;
    localparam logic SEL_CTRL = 1'b1;

    // control nibble fields
    localparam int CTRL_IRQ_EN = 0;
    localparam int CTRL_CP_MODE = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status nibble fields
    localparam int STAT_IRQ = 0;
    localparam int STAT_TX_DONE = 1;
    localparam int STAT_RX_READY = 2;
    localparam int STAT_DSTEER = 3;

    localparam logic [3:0] NIBBLE_RESET = 4'h0;

    // steering sequence
    typedef enum logic [1:0] {
        ST_ARMED = 2'b00,
        ST_SETTLE = 2'b01,
        ST_HELD = 2'b10
    } steer_e;

endpackage : tone_port_pkg

// *** core/pin_sync.sv ***
// per-bit pin synchroniser: three flops and a level register, output moves when stages two and three agree
// assumes inputs are asynchronous to clk; the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be at least one");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            wire agree = (s2_q == s3_q);
            always_ff @(posedge clk) begin
                if (reset) begin
                    s1_q <= INIT[i];
                    s2_q <= INIT[i];
                    s3_q <= INIT[i];
                    lvl_q <= INIT[i];
                end else begin
                    s1_q <= pin[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // a one-cycle disagreement never reaches the logic
                    if (agree) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level[i] = lvl_q;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// *** dv/tone_host_port_assertions.sv ***
// concurrent checks on the tone host port pins
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tone_host_port_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic register_selector,
    input wire logic host_bus_oe,
    input wire logic pair_valid,
    input wire logic cp_level,
    input wire logic pair_detected,
    input wire logic steer_guard_out,
    input wire logic notify_or_tone_out,
    input wire logic notify_or_tone_oe,
    input wire logic tx_load,
    input wire logic [3:0] control
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_bus_float_deselected: assert property (select_n [*8] |-> !host_bus_oe)
        else $error("data bus driven while deselected");
    a_bus_float_no_read: assert property (read_n [*8] |-> !host_bus_oe)
        else $error("data bus driven without a read");
    a_write_gated_sync: assert property (tx_load
        |-> !$past(select_n, 5) && $past(write_n, 3)
        && !$past(write_n, 9) && !$past(register_selector, 4))
        else $error("transmit load without a selected trailing write");
    a_load_one_cycle: assert property (tx_load |=> !tx_load)
        else $error("transmit load longer than one cycle");
    a_ctrl_source: assert property (control != $past(control)
        |-> $past(register_selector, 4))
        else $error("control changed by a data access");
    a_early_rise: assert property (pair_valid |=> pair_detected)
        else $error("early detection missed a valid pair");
    a_early_drop: assert property (!pair_valid |=> !pair_detected)
        else $error("early detection held after loss");
    a_notify_open_drain: assert property (!notify_or_tone_out)
        else $error("notify pin driven high");
    a_irq_quiet: assert property (control == 4'h0 && $past(control) == 4'h0
        |-> !notify_or_tone_oe)
        else $error("notify pulled with interrupts off");
    a_cp_square: assert property (control[1] && $past(control[1])
        |-> notify_or_tone_oe == !$past(cp_level))
        else $error("call progress output does not follow the tone");
    a_guard_low: assert property ((!pair_detected) [*3] |-> !steer_guard_out)
        else $error("guard high without early detection");
    a_guard_hold: assert property (steer_guard_out && pair_valid && pair_detected
        |=> steer_guard_out)
        else $error("guard dropped while early detection holds");

    c_write: cover property (tx_load);
    c_read: cover property ($rose(host_bus_oe));
    c_irq: cover property (notify_or_tone_oe && control[0]);
endmodule : tone_host_port_assertions

bind tone_host_port tone_host_port_assertions tone_host_port_assertions_inst (
    .clk, .reset, .select_n, .read_n, .write_n, .register_selector, .host_bus_oe,
    .pair_valid, .cp_level, .pair_detected, .steer_guard_out, .notify_or_tone_out,
    .notify_or_tone_oe, .tx_load, .control
);
`default_nettype wire

// *** dv/tone_host_mcu.sv ***
// host microcontroller model: strobes, register select and nibble data
// assumes clk is the block clock; every strobe, select and data drive lands 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tone_host_mcu (
    input wire logic clk,
    input wire logic [3:0] host_bus_out,
    input wire logic host_bus_oe,
    output logic select_n = 1'b1,
    output logic read_n = 1'b1,
    output logic write_n = 1'b1,
    output logic register_selector = 1'b0,
    output logic [3:0] host_bus_in
);
    logic [3:0] drv_q = 4'h0;
    logic drv_en = 1'b0;
    logic [3:0] idle_q = 4'h5;
    // a released bus flips every cycle so stale data never passes for valid
    always @(posedge clk) begin
        idle_q <= ~idle_q;
    end
    assign host_bus_in = host_bus_oe ? host_bus_out : (drv_en ? drv_q : idle_q);

    task automatic access(input logic rd, input logic cs_n, input logic sel,
                          input logic [3:0] d);
        @(posedge clk);
        #1;
        select_n = cs_n; // select only inside a qualified access
        register_selector = sel; // held with the strobe
        drv_q = d;
        drv_en = !rd;
        repeat (6) @(posedge clk);
        #1;
        if (rd) begin
            read_n = 1'b0;
        end else begin
            write_n = 1'b0;
        end
        repeat (8) @(posedge clk);
        #1;
        read_n = 1'b1;
        write_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        select_n = 1'b1;
        drv_en = 1'b0;
        // deselect long enough to survive the pin filter
        repeat (6) @(posedge clk);
        #1;
    endtask : access
endmodule : tone_host_mcu
`default_nettype wire

// *** dv/tone_host_port_tb.sv ***
// self-checking bench: host writes and reads, steering, burst notify, call progress
// assumes the host model drives the bus and the checker is bound to the block
`timescale 1ns/1ps
`default_nettype none
module tone_host_port_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic pair_valid = 1'b0;
    logic [3:0] pair_code = 4'h0;
    logic cp_level = 1'b0;
    logic tx_burst_done = 1'b0;
    logic steer_rc = 1'b0;
    logic select_n, read_n, write_n, register_selector, host_bus_oe, pair_detected;
    logic steer_guard_out, steer_guard_oe, notify_or_tone_out, notify_or_tone_oe;
    logic xtal_out, tx_load, oe_q, xq;
    logic [3:0] host_bus_in, host_bus_out, tx_code, control, code;
    wire steer_guard_pin;
    integer seed = 32'hd10465a8;
    int fails = 0;
    int n_compared = 0;
    int n;
    logic [3:0] exp_q[$];

    always #5 clk = ~clk;
    // external time constant, overridden while the guard drives the pin
    assign steer_guard_pin = steer_guard_oe ? steer_guard_out : steer_rc;

    tone_host_port tone_host_port_inst (.clk, .reset, .select_n, .read_n, .write_n,
        .register_selector, .host_bus_in, .host_bus_out, .host_bus_oe, .pair_valid,
        .pair_code, .cp_level, .tx_burst_done, .pair_detected, .steer_guard_pin,
        .steer_guard_out, .steer_guard_oe, .notify_or_tone_out, .notify_or_tone_oe,
        .xtal_out, .tx_code, .tx_load, .control);
    tone_host_mcu tone_host_mcu_inst (.clk, .host_bus_out, .host_bus_oe, .select_n,
        .read_n, .write_n, .register_selector, .host_bus_in);

    task automatic wrap_up();
        if (exp_q.size() != 0) begin
            fails++;
            $display("unexpected at %0t: %0d results never came", $time, exp_q.size());
        end
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic sel, input logic [3:0] d);
        if (!sel) begin
            exp_q.push_back(d);
        end
        tone_host_mcu_inst.access(1'b0, 1'b0, sel, d);
    endtask : wr

    task automatic rd(input logic cs_n, input logic sel, input logic [3:0] e);
        if (!cs_n) begin
            exp_q.push_back(e);
        end
        tone_host_mcu_inst.access(1'b1, cs_n, sel, 4'h0);
    endtask : rd

    task automatic wait_notify(input logic lvl);
        int k;
        k = 0;
        while (notify_or_tone_oe !== lvl) begin
            @(posedge clk);
            k++;
            if (k > 600) begin
                fails++;
                $display("unexpected at %0t: notify never settled", $time);
                wrap_up();
            end
        end
        #1;
    endtask : wait_notify

    // results come as a load pulse or the start of a driven read
    always @(posedge clk) begin
        oe_q <= host_bus_oe;
        if (tx_load === 1'b1 || (host_bus_oe === 1'b1 && oe_q !== 1'b1)) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("unexpected at %0t: result with nothing expected", $time);
            end else begin
                chk(tx_load ? tx_code : host_bus_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        chk({host_bus_oe, steer_guard_oe, notify_or_tone_oe, notify_or_tone_out}, 4'h0);
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, 4'($random(seed)));
        end
        wr(1'b1, 4'h1);
        chk(control, 4'h1);
        rd(1'b1, 1'b0, 4'h0);
        rd(1'b0, 1'b0, 4'h0);
        $display("bus access test done");
        for (int i = 0; i < 2; i++) begin
            code = 4'($random(seed));
            pair_code = code;
            pair_valid = 1'b1;
            repeat (10) @(posedge clk);
            #1;
            steer_rc = 1'b1;
            wait_notify(1'b1);
            chk({1'b0, pair_detected, steer_guard_oe, steer_guard_out}, 4'h7);
            steer_rc = 1'b0;
            rd(1'b0, 1'b1, 4'hd);
            rd(1'b0, 1'b0, code);
            pair_valid = 1'b0;
            wait_notify(1'b0);
            chk({1'b0, pair_detected, steer_guard_oe, steer_guard_out}, 4'h2);
        end
        $display("steering test done");
        tx_burst_done = 1'b1;
        @(posedge clk);
        #1;
        tx_burst_done = 1'b0;
        wait_notify(1'b1);
        rd(1'b0, 1'b1, 4'h3);
        wait_notify(1'b0);
        $display("burst notify test done");
        wr(1'b1, 4'h2);
        chk(control, 4'h2);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            chk({3'h0, notify_or_tone_oe}, {3'h0, ~cp_level});
            cp_level = 1'($random(seed));
        end
        wr(1'b1, 4'h0);
        $display("call progress test done");
        // reference edges in 1000 cycles of 10 ns at the colour-burst rate
        n = 0;
        xq = xtal_out;
        repeat (1000) begin
            @(posedge clk);
            #1;
            n += int'(xtal_out !== xq);
            xq = xtal_out;
        end
        chk(4'(n >= 71 && n <= 72), 4'h1);
        $display("reference clock test done");
        wrap_up();
    end
endmodule : tone_host_port_tb
`default_nettype wire
